/* File: bench/serial_status_output_encoder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_status_output_encoder_tb_top;
  import sso_pkg::*;
  localparam int TICK = 1;

  logic          sys_clk_i, link_clk, rstn;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic          reg_we, reg_re;
  logic [7:0]    status, m_word, m_frames, m_errs;
  logic          ser_data, ser_clk, ser_clk_en, m_sync;
  logic [3:0]    m_n;
  logic [15:0]   m_bit;
  int            err_count, comparisons;

  sso_enc #(.N_IN(8), .TICK_CYC(TICK)) u_sso_enc (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn), .link_clk_i(link_clk),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .status_i(status),
    .ser_data_o(ser_data), .ser_clk_o(ser_clk), .ser_clk_en_o(ser_clk_en)
  );

  sso_rx_model u_sso_rx_model (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn), .sync_i(m_sync), .n_i(m_n),
    .bit_cyc_i(m_bit), .ser_data_i(ser_data), .ser_clk_i(ser_clk),
    .word_o(m_word), .frames_o(m_frames), .errs_o(m_errs)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // odd offset keeps link edges away from system edges
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic int bit_cyc(input int bc);
    return (bc < 17 ? 40 + 10 * bc : 250 + 50 * (bc - 17)) * 4 * TICK;
  endfunction

  function automatic int gap_cyc(input int gc);
    return (gc < 25 ? 100 + 100 * gc : 3000 + 500 * (gc - 25)) * 4 * TICK;
  endfunction

  task automatic reg_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge sys_clk_i);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk_i);
    reg_re <= 1'b0;
    @(negedge sys_clk_i);
    d = reg_rdata;
    @(negedge sys_clk_i);
    chk(reg_rdata, 32'h0000_0000, "read data held over");
    @(posedge sys_clk_i);
  endtask

  // waits for the level, then counts system cycles while it lasts
  task automatic lvl_len(input bit on_clk, input logic lv, output int n);
    int guard;
    n = 0;
    guard = 0;
    while ((on_clk ? ser_clk : ser_data) !== lv && guard < 20000) begin
      @(posedge sys_clk_i);
      guard++;
    end
    while ((on_clk ? ser_clk : ser_data) === lv && n < 20000) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  task automatic wait_frame();
    logic [7:0] f;
    int guard;
    f = m_frames;
    guard = 0;
    while (m_frames === f && guard < 30000) begin
      @(posedge sys_clk_i);
      guard++;
    end
    chk(32'(guard < 30000), 32'h0000_0001, "train not received");
  endtask

  // pin levels lag by the link synchroniser, so lengths get two cycles of slack
  task automatic async_run(input int n_cfg, input int n_exp, input logic [7:0] st,
                           input logic [7:0] st2, input int bc, input int gc);
    int t, g, len;
    logic [7:0] mask, f;
    logic [DW-1:0] rd;
    t = bit_cyc(bc);
    g = gap_cyc(gc);
    mask = 8'((1 << n_exp) - 1);
    m_sync <= 1'b0;
    m_n <= 4'(n_exp);
    m_bit <= 16'(t);
    status <= st;
    reg_wr(REG_BITLEN, 32'(bc));
    reg_wr(REG_GAP, 32'(gc));
    reg_wr(REG_CTRL, 32'(n_cfg << CTRL_N_LSB) | 32'h0000_0001);
    lvl_len(1'b0, 1'b0, len);
    chk(32'(len >= t - 2 && len <= t + 2), 32'h0000_0001, "start bit length");
    chk(32'({ser_clk_en, ser_clk}), 32'h0000_0000, "clock pin in async mode");
    wait_frame();
    chk(32'(m_word), 32'(st & mask), "first train bits");
    status <= st2;
    lvl_len(1'b0, 1'b1, len);
    chk(32'(len >= g - 2 && len <= g + 2), 32'h0000_0001, "gap length");
    wait_frame();
    chk(32'(m_word), 32'(st2 & mask), "repeated train bits");
    reg_wr(REG_CTRL, 32'h0000_0000);
    f = m_frames;
    repeat (g + (n_exp + 1) * t + 100) @(posedge sys_clk_i);
    chk(32'(m_frames), 32'(f), "train after disable");
    chk(32'(ser_data), 32'h0000_0001, "idle level");
    reg_rd(REG_STATUS, rd);
    chk(32'(rd[3:0]), 32'h0000_0001, "state after disable");
    chk(32'(rd[23:16]), 32'(st2), "last sampled inputs");
    chk(32'(m_errs), 32'h0000_0000, "coding faults");
  endtask

  task automatic s_reset();
    logic [DW-1:0] rd;
    chk(32'({ser_data, ser_clk, ser_clk_en}), 32'h0000_0004, "pins after reset");
    reg_rd(REG_CTRL, rd);
    chk(rd, 32'h0000_0080, "control reset value");
    reg_rd(REG_BITLEN, rd);
    chk(rd, 32'h0000_0000, "bit length reset value");
    reg_rd(REG_GAP, rd);
    chk(rd, 32'h0000_0000, "gap reset value");
    reg_wr(8'h14, 32'hFFFF_FFFF);
    reg_rd(8'h14, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    reg_rd(REG_CTRL, rd);
    chk(rd, 32'h0000_0080, "unmapped write leaked");
    status <= 8'h5A;
    reg_rd(REG_INPUTS, rd);
    chk(rd, 32'h0000_005A, "live inputs");
  endtask

  task automatic s_async_fine();
    async_run(8, 8, 8'hA5, 8'h3C, 0, 1);
  endtask

  // count 1 is below the async minimum and must act as 2
  task automatic s_async_coarse();
    async_run(1, 2, 8'hFF, 8'h01, 17, 25);
  endtask

  task automatic s_sync();
    int t, len;
    t = bit_cyc(16);
    m_sync <= 1'b1;
    m_n <= 4'h3;
    m_bit <= 16'(t);
    status <= 8'h05;
    reg_wr(REG_BITLEN, 32'h0000_0010);
    reg_wr(REG_GAP, 32'h0000_0000);
    reg_wr(REG_CTRL, 32'h0000_0022);
    repeat (5) @(posedge sys_clk_i);
    chk(32'({ser_data, ser_clk, ser_clk_en}), 32'h0000_0001, "sync idle pins");
    reg_wr(REG_CTRL, 32'h0000_0023);
    lvl_len(1'b1, 1'b1, len);
    chk(32'(len >= t / 2 - 2 && len <= t / 2 + 2), 32'h0000_0001, "clock high");
    wait_frame();
    chk(32'(m_word), 32'h0000_0005, "sync bits");
    repeat (t) @(posedge sys_clk_i);
    chk(32'({ser_data, ser_clk}), 32'h0000_0000, "sync gap level");
    reg_wr(REG_CTRL, 32'h0000_0002);
    chk(32'(m_errs), 32'h0000_0000, "data moved with clock high");
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk_i);
    err_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    status = '0;
    m_sync = 1'b0;
    m_n = 4'h8;
    m_bit = 16'h00A0;
    repeat (10) @(posedge sys_clk_i);
    rstn <= 1'b1;
    @(posedge sys_clk_i);
    s_reset();
    s_async_fine();
    s_async_coarse();
    s_sync();
    wrap_up();
  end
endmodule // serial_status_output_encoder_tb_top
`default_nettype wire

/* File: bench/sso_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sso_rx_model (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // receiver setup
  input  wire logic        sync_i,
  input  wire logic [3:0]  n_i,
  input  wire logic [15:0] bit_cyc_i,
  // serial pins
  input  wire logic        ser_data_i,
  input  wire logic        ser_clk_i,
  // decoded result
  output logic      [7:0]  word_o,
  output logic      [7:0]  frames_o,
  output logic      [7:0]  errs_o
);
  logic [7:0] a_word_q, a_fr_q, a_err_q, s_word_q, s_sh_q, s_fr_q, s_err_q, tmp;
  logic [3:0] s_cnt_q;
  logic       s_last_q, d1, d2;

  assign word_o   = sync_i ? s_word_q : a_word_q;
  assign frames_o = a_fr_q + s_fr_q;
  assign errs_o   = a_err_q + s_err_q;

  initial begin
    {a_word_q, a_fr_q, a_err_q, s_word_q, s_sh_q, s_fr_q, s_err_q} = '0;
    s_cnt_q = '0;
    s_last_q = 1'b0;
  end

  // resyncs on every start edge; while decoding, the mid-bit edges are ignored
  always @(negedge ser_data_i) begin
    if (rstn_i === 1'b1 && !sync_i) begin
      tmp = '0;
      repeat (bit_cyc_i / 2) @(posedge sys_clk_i);
      if (ser_data_i !== 1'b0) a_err_q++;
      for (int k = 0; k < n_i; k++) begin
        repeat (k == 0 ? bit_cyc_i * 3 / 4 : bit_cyc_i / 2) @(posedge sys_clk_i);
        d1 = ser_data_i;
        repeat (bit_cyc_i / 2) @(posedge sys_clk_i);
        d2 = ser_data_i;
        tmp[k] = d1;
        if (d1 === d2) a_err_q++;
      end
      a_word_q = tmp;
      a_fr_q++;
    end
  end

  always @(posedge ser_clk_i) begin
    if (rstn_i === 1'b1 && sync_i) begin
      s_sh_q[s_cnt_q[2:0]] = ser_data_i;
      s_last_q = ser_data_i;
      s_cnt_q++;
      if (s_cnt_q == n_i) begin
        s_word_q = s_sh_q;
        s_sh_q = '0;
        s_cnt_q = '0;
        s_fr_q++;
      end
    end
  end

  // data moving while the clock is high would be taken wrongly by a real receiver
  always @(negedge ser_clk_i) begin
    if (sync_i && ser_data_i !== s_last_q) s_err_q++;
  end
endmodule // sso_rx_model
`default_nettype wire

/* File: hw/sso_enc.sv */
// What this block does
// - asynchronous mode: data line sits high whenever nothing is sent
// - asynchronous mode: every train opens with one low start bit of one bit period
// - asynchronous mode: a low input is sent as a mid-bit rising edge
// - asynchronous mode: a high input is sent as a mid-bit falling edge
// - asynchronous mode: data line stays high in the gap between trains
// - asynchronous mode: the clock output is not driven, only data carries the train
// - synchronous mode: data and clock both low while idle
// - synchronous mode: send n input bits on data, each timed by a clock pulse
// - synchronous mode: data line stays low in the gap between trains
// - input count settable: two to eight asynchronous, three to eight synchronous
// - bit period 40 to 200 ms by 10 ms, or 250 to 950 ms by 50 ms
// - gap 100 ms to 2.5 s by 100 ms, or 3 to 6 s by 500 ms
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sso_enc #(
  parameter int unsigned N_IN     = sso_pkg::N_MAX,
  parameter int unsigned TICK_CYC = sso_pkg::TICK_CYCLES
) (
  // system clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // link clock
  input  wire logic                   link_clk_i,
  // register port
  input  wire logic [sso_pkg::AW-1:0] reg_addr_i,
  input  wire logic [sso_pkg::DW-1:0] reg_wdata_i,
  input  wire logic                   reg_we_i,
  input  wire logic                   reg_re_i,
  output logic      [sso_pkg::DW-1:0] reg_rdata_o,
  // input states to serialise
  input  wire logic [N_IN-1:0]        status_i,
  // serial pins, link domain
  output logic                        ser_data_o,
  output logic                        ser_clk_o,
  output logic                        ser_clk_en_o
);
  import sso_pkg::*;

  sso_cfg_t        cfg_q;
  sso_cfg_t        cfg_d;
  logic [DW-1:0]   rdata_q;
  logic [DW-1:0]   rdata_d;
  sso_state_t      state_q;
  sso_state_t      state_d;
  sso_run_t        run_q;
  sso_run_t        run_d;
  logic [N_MAX-1:0] sample_q;
  logic [N_MAX-1:0] sample_d;
  logic [3:0]      idx_q;
  logic [3:0]      idx_d;
  logic [TW-1:0]   cnt_q;
  logic [TW-1:0]   cnt_d;
  sso_line_t       line_q;
  sso_line_t       line_d;
  sso_line_t       line_link;
  logic            tick;
  logic            tick_clr;
  logic            train_go;
  logic            phase_end;
  logic [TW-1:0]   phase_len;
  logic [TW-1:0]   half;
  logic [TW-1:0]   quarter;
  logic            cur_bit;

  function automatic logic [3:0] clamp_n(input logic [3:0] n, input logic sm);
    logic [3:0] lo;
    lo = sm ? 4'(N_MIN_SYNC) : 4'(N_MIN_ASYNC);
    if (n < lo) return lo;
    if (n > 4'(N_IN)) return 4'(N_IN);
    return n;
  endfunction

  // ---------------------------------------------------------------- registers
  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = '0;
    if (reg_we_i) begin
      case (reg_addr_i)
        REG_CTRL: begin
          cfg_d.enable    = reg_wdata_i[CTRL_EN_BIT];
          cfg_d.sync_mode = reg_wdata_i[CTRL_MODE_BIT];
          cfg_d.n_inputs  = reg_wdata_i[CTRL_N_LSB +: 4];
        end
        REG_BITLEN: cfg_d.bit_code = reg_wdata_i[4:0];
        REG_GAP:    cfg_d.gap_code = reg_wdata_i[4:0];
        default: ;
      endcase
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        REG_CTRL: begin
          rdata_d[CTRL_EN_BIT]       = cfg_q.enable;
          rdata_d[CTRL_MODE_BIT]     = cfg_q.sync_mode;
          rdata_d[CTRL_N_LSB +: 4]   = cfg_q.n_inputs;
        end
        REG_BITLEN: rdata_d[4:0] = cfg_q.bit_code;
        REG_GAP:    rdata_d[4:0] = cfg_q.gap_code;
        REG_STATUS: begin
          rdata_d[3:0]                  = state_q;
          rdata_d[ST_LINE_LSB +: 3]     = line_q;
          rdata_d[ST_IDX_LSB +: 4]      = idx_q;
          rdata_d[ST_SAMPLE_LSB +: N_MAX] = sample_q;
        end
        REG_INPUTS: rdata_d[N_MAX-1:0] = N_MAX'(status_i);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q   <= CFG_RST;
      rdata_q <= '0;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ---------------------------------------------------------------- timebase
  // clear only while leaving idle: a gap already ends on a tick, and
  // clearing from train_go there would loop back through phase_end
  assign tick_clr = cfg_q.enable && state_q == SSO_IDLE;

  sso_tick #(
    .CYC (TICK_CYC)
  ) u_tick (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .clr_i  (tick_clr),
    .tick_o (tick)
  );

  // ---------------------------------------------------------------- sequencer
  assign phase_len = (state_q == SSO_GAP) ? run_q.gap_ticks : run_q.bit_ticks;
  assign phase_end = tick && cnt_q == phase_len - 16'h0001;
  // a new train starts from idle, or right after a gap while still enabled
  assign train_go  = cfg_q.enable &&
                     (state_q == SSO_IDLE || (state_q == SSO_GAP && phase_end));

  always_comb begin
    state_d  = state_q;
    run_d    = run_q;
    sample_d = sample_q;
    idx_d    = idx_q;
    cnt_d    = cnt_q;
    if (tick) cnt_d = phase_end ? '0 : cnt_q + 16'h0001;
    // settings are latched per train so a write never tears a train apart
    if (train_go) begin
      run_d.sync_mode = cfg_q.sync_mode;
      run_d.n_inputs  = clamp_n(cfg_q.n_inputs, cfg_q.sync_mode);
      run_d.bit_ticks = sso_bit_ticks(cfg_q.bit_code);
      run_d.gap_ticks = sso_gap_ticks(cfg_q.gap_code);
      sample_d        = N_MAX'(status_i);
      idx_d           = '0;
      cnt_d           = '0;
      state_d         = cfg_q.sync_mode ? SSO_DATA : SSO_START;
    end else begin
      case (state_q)
        SSO_IDLE: state_d = SSO_IDLE;
        SSO_START: begin
          if (phase_end) state_d = SSO_DATA;
        end
        SSO_DATA: begin
          if (phase_end) begin
            if (idx_q == run_q.n_inputs - 4'h1) state_d = SSO_GAP;
            else idx_d = idx_q + 4'h1;
          end
        end
        SSO_GAP: begin
          if (phase_end) state_d = SSO_IDLE;
        end
        default: state_d = SSO_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------- line coder
  // levels are worked out from the next state so line_q always matches state_q
  always_comb begin
    half    = run_d.bit_ticks >> 1;
    quarter = run_d.bit_ticks >> 2;
    cur_bit = sample_d[idx_d[2:0]];
    // idle level follows the mode being written, so it never lags a cycle
    line_d  = cfg_d.sync_mode ? LINE_SYNC : LINE_ASYNC;
    case (state_d)
      SSO_IDLE: ;
      SSO_START: begin
        line_d      = LINE_ASYNC;
        line_d.data = 1'h0;
      end
      SSO_DATA: begin
        if (run_d.sync_mode) begin
          line_d      = LINE_SYNC;
          line_d.data = cur_bit;
          line_d.clk  = cnt_d >= quarter && cnt_d < half + quarter;
        end else begin
          line_d      = LINE_ASYNC;
          line_d.data = (cnt_d < half) ? cur_bit : !cur_bit;
        end
      end
      SSO_GAP: line_d = run_d.sync_mode ? LINE_SYNC : LINE_ASYNC;
      default: line_d = LINE_ASYNC;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q  <= SSO_IDLE;
      run_q    <= '0;
      sample_q <= '0;
      idx_q    <= '0;
      cnt_q    <= '0;
      line_q   <= LINE_ASYNC;
    end else begin
      state_q  <= state_d;
      run_q    <= run_d;
      sample_q <= sample_d;
      idx_q    <= idx_d;
      cnt_q    <= cnt_d;
      line_q   <= line_d;
    end
  end

  // ---------------------------------------------------------------- link side
  // line levels are held for whole milliseconds, so a plain level
  // synchroniser into the pin clock is enough
  sso_sync #(
    .W   (3),
    .RST (LINE_ASYNC)
  ) u_sync (
    .clk_i  (link_clk_i),
    .rstn_i (rstn_i),
    .lvl_i  (line_q),
    .lvl_o  (line_link)
  );

  assign ser_data_o   = line_link.data;
  assign ser_clk_o    = line_link.clk;
  assign ser_clk_en_o = line_link.clk_en;

  // ---------------------------------------------------------------- checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  idle_async_high_a: assert property (
    state_q == SSO_IDLE && !cfg_q.sync_mode |-> line_q.data)
    else $error("async idle line not high");

  start_bit_low_a: assert property (
    $rose(state_q == SSO_START) |-> (!line_q.data && state_q == SSO_START) [*8])
    else $error("start bit not held low");

  manch_zero_a: assert property (
    state_q == SSO_DATA && !run_q.sync_mode && !sample_q[idx_q[2:0]] |->
      line_q.data == (cnt_q >= (run_q.bit_ticks >> 1)))
    else $error("low input not coded as mid-bit rise");

  manch_one_a: assert property (
    state_q == SSO_DATA && !run_q.sync_mode && sample_q[idx_q[2:0]] |->
      line_q.data == (cnt_q < (run_q.bit_ticks >> 1)))
    else $error("high input not coded as mid-bit fall");

  gap_async_high_a: assert property (
    state_q == SSO_GAP && !run_q.sync_mode |-> line_q.data && !line_q.clk)
    else $error("async gap line not high");

  async_no_clock_a: assert property (
    (state_q == SSO_IDLE ? !cfg_q.sync_mode : !run_q.sync_mode) |->
      !line_q.clk_en && !line_q.clk)
    else $error("clock driven in async mode");

  sync_idle_low_a: assert property (
    state_q == SSO_IDLE && cfg_q.sync_mode |-> !line_q.data && !line_q.clk)
    else $error("sync idle lines not low");

  sync_data_stable_a: assert property (
    line_q.clk && $past(line_q.clk) |-> $stable(line_q.data) && state_q == SSO_DATA)
    else $error("data moved while clock high");

  gap_sync_low_a: assert property (
    state_q == SSO_GAP && run_q.sync_mode |-> !line_q.data && !line_q.clk)
    else $error("sync gap line not low");

  count_range_a: assert property (
    state_q != SSO_IDLE |-> run_q.n_inputs <= 4'(N_IN) &&
      run_q.n_inputs >= (run_q.sync_mode ? 4'(N_MIN_SYNC) : 4'(N_MIN_ASYNC)))
    else $error("input count out of range");

  bit_len_a: assert property (
    state_q != SSO_IDLE |->
      (run_q.bit_ticks >= TW'(BIT_FINE_MIN_MS * TICKS_PER_MS) &&
       run_q.bit_ticks <= TW'(BIT_MAX_MS * TICKS_PER_MS) &&
       run_q.bit_ticks % TW'(BIT_FINE_STEP_MS * TICKS_PER_MS) == '0))
    else $error("bit period illegal");

  gap_len_a: assert property (
    state_q != SSO_IDLE |->
      (run_q.gap_ticks >= TW'(GAP_FINE_MIN_MS * TICKS_PER_MS) &&
       run_q.gap_ticks <= TW'(GAP_MAX_MS * TICKS_PER_MS) &&
       run_q.gap_ticks % TW'(GAP_FINE_STEP_MS * TICKS_PER_MS) == '0))
    else $error("gap illegal");

  sample_order_a: assert property (
    state_q == SSO_DATA && phase_end && idx_q != run_q.n_inputs - 4'h1 |=>
      idx_q == $past(idx_q) + 4'h1 && sample_q == $past(sample_q))
    else $error("bits not sent in index order");

  sample_capture_a: assert property (
    train_go |=> sample_q == N_MAX'($past(status_i)) && idx_q == '0)
    else $error("inputs not sampled at train start");

  sync_clk_mid_a: assert property (
    state_q == SSO_DATA && run_q.sync_mode && cnt_q < (run_q.bit_ticks >> 2) |->
      !line_q.clk)
    else $error("clock high in first quarter of bit");

  async_train_c: cover property (state_q == SSO_START ##1 state_q == SSO_DATA);
  sync_train_c: cover property (state_q == SSO_DATA && run_q.sync_mode && line_q.clk);
  repeat_train_c: cover property (state_q == SSO_GAP ##1 state_q != SSO_GAP &&
                                  state_q != SSO_IDLE);
  back_idle_c: cover property (state_q == SSO_GAP ##1 state_q == SSO_IDLE);

endmodule // sso_enc
`default_nettype wire

/* File: hw/sso_pkg.sv */
package sso_pkg;

  // timebase: one tick per quarter millisecond keeps every Manchester
  // half and clock quarter an exact whole number of ticks
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS       = 250_000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_MS  = 4;
  localparam int unsigned TW            = 16;

  // bit length table: fine codes then coarse codes
  localparam int unsigned BIT_FINE_MIN_MS    = 40;
  localparam int unsigned BIT_FINE_STEP_MS   = 10;
  localparam int unsigned BIT_FINE_CODES     = 17;
  localparam int unsigned BIT_COARSE_MIN_MS  = 250;
  localparam int unsigned BIT_COARSE_STEP_MS = 50;
  localparam int unsigned BIT_MAX_MS         = 950;

  // gap between trains
  localparam int unsigned GAP_FINE_MIN_MS    = 100;
  localparam int unsigned GAP_FINE_STEP_MS   = 100;
  localparam int unsigned GAP_FINE_CODES     = 25;
  localparam int unsigned GAP_COARSE_MIN_MS  = 3000;
  localparam int unsigned GAP_COARSE_STEP_MS = 500;
  localparam int unsigned GAP_MAX_MS         = 6000;

  localparam int unsigned N_MIN_ASYNC = 2;
  localparam int unsigned N_MIN_SYNC  = 3;
  localparam int unsigned N_MAX       = 8;

  // register port
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam logic [AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [AW-1:0] REG_BITLEN = 8'h04;
  localparam logic [AW-1:0] REG_GAP    = 8'h08;
  localparam logic [AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [AW-1:0] REG_INPUTS = 8'h10;

  // field positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CTRL_N_LSB    = 4;
  localparam int unsigned ST_LINE_LSB   = 4;
  localparam int unsigned ST_IDX_LSB    = 8;
  localparam int unsigned ST_SAMPLE_LSB = 16;

  typedef enum logic [3:0] {
    SSO_IDLE  = 4'h1,
    SSO_START = 4'h2,
    SSO_DATA  = 4'h4,
    SSO_GAP   = 4'h8
  } sso_state_t;

  typedef struct packed {
    logic       enable;
    logic       sync_mode;
    logic [3:0] n_inputs;
    logic [4:0] bit_code;
    logic [4:0] gap_code;
  } sso_cfg_t;

  typedef struct packed {
    logic          sync_mode;
    logic [3:0]    n_inputs;
    logic [TW-1:0] bit_ticks;
    logic [TW-1:0] gap_ticks;
  } sso_run_t;

  typedef struct packed {
    logic data;
    logic clk;
    logic clk_en;
  } sso_line_t;

  localparam sso_cfg_t  CFG_RST    = '{enable: 1'h0, sync_mode: 1'h0, n_inputs: 4'h8,
                                       bit_code: 5'h00, gap_code: 5'h00};
  localparam sso_line_t LINE_ASYNC = '{data: 1'h1, clk: 1'h0, clk_en: 1'h0};
  localparam sso_line_t LINE_SYNC  = '{data: 1'h0, clk: 1'h0, clk_en: 1'h1};

  function automatic logic [TW-1:0] sso_bit_ticks(input logic [4:0] code);
    int unsigned ms;
    if (code < BIT_FINE_CODES) ms = BIT_FINE_MIN_MS + BIT_FINE_STEP_MS * code;
    else ms = BIT_COARSE_MIN_MS + BIT_COARSE_STEP_MS * (code - BIT_FINE_CODES);
    return TW'(ms * TICKS_PER_MS);
  endfunction

  function automatic logic [TW-1:0] sso_gap_ticks(input logic [4:0] code);
    int unsigned ms;
    if (code < GAP_FINE_CODES) ms = GAP_FINE_MIN_MS + GAP_FINE_STEP_MS * code;
    else ms = GAP_COARSE_MIN_MS + GAP_COARSE_STEP_MS * (code - GAP_FINE_CODES);
    return TW'(ms * TICKS_PER_MS);
  endfunction

endpackage

/* File: hw/sso_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sso_sync #(
  parameter int unsigned     W   = 3,
  parameter logic [W-1:0]    RST = '0
) (
  // link clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // level from the system domain
  input  wire logic [W-1:0] lvl_i,
  // level in the link domain
  output logic      [W-1:0] lvl_o
);
  import sso_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // data and clock never move in the same system cycle; clk_en only moves
  // with the mode while the clock pin is low, so per-bit skew of one link
  // cycle cannot show a harmful combination
  always_comb begin
    meta_d = lvl_i;
    out_d  = meta_q;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RST;
      out_q  <= RST;
    end else begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign lvl_o = out_q;

endmodule // sso_sync
`default_nettype wire

/* File: hw/sso_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module sso_tick #(
  parameter int unsigned CYC = sso_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // control
  input  wire logic clr_i,
  // timebase
  output logic      tick_o
);
  import sso_pkg::*;

  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // restart on clear so a train's first tick is a full tick away
  always_comb begin
    if (clr_i || cnt_q == LAST) cnt_d = '0;
    else cnt_d = cnt_q + CW'(1);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

  assign tick_o = !clr_i && cnt_q == LAST;

endmodule // sso_tick
`default_nettype wire
